// ### verilog/cvd_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 12-bit data-memory address and 8-bit register data
`ifndef CVD_DEFS_SVH
`define CVD_DEFS_SVH
// converter registers seen at their low-bank alias
`define CVD_OFS_RES0L_ALIAS 12'h09b
`define CVD_OFS_RES0H_ALIAS 12'h09c
`define CVD_OFS_CTRL0_ALIAS 12'h09d
`define CVD_OFS_CTRL1_ALIAS 12'h09e
// sensing bank
`define CVD_OFS_CTRL0       12'h711
`define CVD_OFS_CTRL1       12'h712
`define CVD_OFS_TRIG        12'h713
`define CVD_OFS_POL         12'h714
`define CVD_OFS_STAT        12'h715
`define CVD_OFS_PRE         12'h716
`define CVD_OFS_ACQ         12'h717
`define CVD_OFS_GRD         12'h718
`define CVD_OFS_CAP         12'h719
`define CVD_OFS_RES0L       12'h71a
`define CVD_OFS_RES0H       12'h71b
`define CVD_OFS_RES1L       12'h71c
`define CVD_OFS_RES1H       12'h71d
// field positions
`define CVD_BIT_ON          0
`define CVD_BIT_GO          1
`define CVD_BIT_FMT         7
`define CVD_BIT_DSEN        0
`define CVD_BIT_IPEN        1
`define CVD_BIT_OOEN        3
`define CVD_BIT_OEN         4
`define CVD_BIT_OLEN        5
`define CVD_BIT_IPPOL       6
`define CVD_BIT_EPPOL       7
`define CVD_BIT_GRD_A       7
`define CVD_BIT_GRD_B       6
`define CVD_BIT_GRD_POL     5
// reset value of every register
`define CVD_REG_RST         8'h00
// cycles between first and second conversion of a double sample
`define CVD_GAP_CYCLES      7'd2
`endif

// ### verilog/cvd_pkg.sv
// types shared by the sensing sequencer and its helpers
// assumes cvd_defs.svh holds every number
package cvd_pkg;
  typedef enum logic [2:0] {
    CVD_IDLE = 3'b000,
    CVD_PRE  = 3'b001,
    CVD_ACQ  = 3'b010,
    CVD_CONV = 3'b011,
    CVD_GAP  = 3'b100
  } cvd_state_type;

  typedef struct packed {
    cvd_state_type st;
    logic          second;
    logic          start;
    logic          done;
    logic [4:0]    trig_prev;
    logic [7:0]    ctrl0, ctrl1, trig, pol, pre, acq, grd, cap, rdata;
    logic [15:0]   res0, res1;
  } cvd_main_type;

  typedef struct packed {
    logic a_lvl;
    logic b_lvl;
    logic inv_q;
  } cvd_guard_type;
endpackage

// ### verilog/cvd_seq_if.sv
// carries sequencer stage and live settings to the pin drive
// assumes one clock domain shared by both ends
`timescale 1ns/10ps
interface cvd_seq_if;
  import cvd_pkg::*;
  cvd_state_type seq_st;
  logic          inv2;
  logic          pre_start;
  logic          acq_start;
  logic          conv_on;
  logic          grd_a_en;
  logic          grd_b_en;
  logic          grd_pol;
  logic          ovr_en;
  logic          int_pol;

  modport seq (output seq_st, inv2, pre_start, acq_start, conv_on, grd_a_en,
               grd_b_en, grd_pol, ovr_en, int_pol);
  modport drv (input seq_st, inv2, pre_start, acq_start, conv_on, grd_a_en,
               grd_b_en, grd_pol, ovr_en, int_pol);
endinterface

// ### verilog/cvd_stage_timer.sv
// down counter timing pre-charge, acquisition and the double-sample gap
// assumes load_i is a one-cycle pulse on entry into a timed stage
`timescale 1ns/10ps
module cvd_stage_timer #(
  parameter int W = 7
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // control
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  // status
  output logic              done_o
);
  logic [W-1:0] remain, next_remain;

  // stage ends in its last counted cycle
  assign done_o = (remain == W'(1));

  // load on entry, else count down to zero
  always_comb begin
    next_remain = remain;
    if (load_i) begin
      next_remain = count_i;
    end else if (remain != '0) begin
      next_remain = remain - W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remain <= '0;
    end else begin
      remain <= next_remain;
    end
  end
endmodule

// ### verilog/cvd_guard_drive.sv
// guard ring and monitor pin drive for the sensing sequencer
// assumes stage-start pulses come one cycle before the stage shows
`timescale 1ns/10ps
module cvd_guard_drive
  import cvd_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // sequencer side
  cvd_seq_if.drv    sq,
  // pins
  output logic      guard_a_o,
  output logic      guard_a_oe_o,
  output logic      guard_b_o,
  output logic      guard_b_oe_o,
  output logic      mon_pin_o,
  output logic      mon_pin_oe_o
);
  cvd_guard_type s, n;
  logic          lvl;

  // polarity used by hardware; the stored bit is never touched
  assign lvl = sq.grd_pol ^ sq.inv2;

  // levels latch only at stage starts and hold between them
  always_comb begin
    n = s;
    if (sq.pre_start) begin
      n.a_lvl = lvl;
      n.b_lvl = lvl;
      n.inv_q = sq.inv2;
    end
    if (sq.acq_start) begin
      n.a_lvl = ~lvl;
      n.b_lvl = lvl;
      n.inv_q = sq.inv2;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // guards drive whenever enabled and on, released otherwise
  assign guard_a_o    = s.a_lvl;
  assign guard_b_o    = s.b_lvl;
  assign guard_a_oe_o = sq.grd_a_en & sq.conv_on;
  assign guard_b_oe_o = sq.grd_b_en & sq.conv_on;

  // override only in pre-charge; port direction rules elsewhere
  assign mon_pin_oe_o = sq.ovr_en & (sq.seq_st == CVD_PRE);
  assign mon_pin_o    = sq.int_pol ^ s.inv_q;

  a_guard_active: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (sq.grd_a_en && sq.conv_on) |-> guard_a_oe_o)
    else $error("guard a not driven while enabled");
  a_guard_release: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !sq.conv_on |-> (!guard_a_oe_o && !guard_b_oe_o))
    else $error("guard driven while converter off");
  a_guard_pre_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (sq.pre_start && !sq.acq_start) |=> (guard_a_o == $past(lvl) && guard_b_o == $past(lvl)))
    else $error("guard level wrong at pre-charge start");
  a_guard_acq_flip: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sq.acq_start |=> (guard_a_o == !$past(lvl)))
    else $error("guard a not inverted at acquisition");
  a_monitor_free: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (sq.seq_st != CVD_PRE) |-> !mon_pin_oe_o)
    else $error("monitor pin overridden outside pre-charge");
endmodule

// ### verilog/cvd_guard_and_bus_control.sv
// capacitive-divider sensing sequencer, register bank and pin control
// assumes a single-cycle data-memory write port and an external
// converter core that answers conv_start_o with conv_done_i
`timescale 1ns/10ps
`include "cvd_defs.svh"
module cvd_guard_and_bus_control
  import cvd_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // register port
  input  wire logic       reg_wr_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // special event trigger sources, codes 1 to 5
  input  wire logic [4:0] trig_src_i,
  // converter core
  output logic            conv_start_o,
  output logic      [4:0] chan_sel_o,
  input  wire logic       conv_done_i,
  input  wire logic [9:0] conv_result_i,
  // analog switches
  output logic            hold_pre_level_o,
  output logic            pad_override_o,
  output logic            pad_pre_level_o,
  output logic      [2:0] extra_cap_o,
  output logic            passgate_o,
  output logic            low_z_o,
  // interrupt flag set request
  output logic            irq_set_o,
  // pins
  output logic            guard_a_o,
  output logic            guard_a_oe_o,
  output logic            guard_b_o,
  output logic            guard_b_oe_o,
  output logic            mon_pin_o,
  output logic            mon_pin_oe_o
);
  cvd_main_type s, n;
  logic         tmr_load;
  logic [6:0]   tmr_count;
  logic         tmr_done;
  logic         on, go, dbl, inv, trig_hit;
  logic [4:0]   trig_edge;
  logic [7:0]   rv;
  logic [11:0]  home;

  cvd_seq_if sq ();

  // low-bank alias folds onto its sensing-bank home
  function automatic logic [11:0] reg_home(input logic [11:0] a);
    unique case (a)
      `CVD_OFS_RES0L_ALIAS: reg_home = `CVD_OFS_RES0L;
      `CVD_OFS_RES0H_ALIAS: reg_home = `CVD_OFS_RES0H;
      `CVD_OFS_CTRL0_ALIAS: reg_home = `CVD_OFS_CTRL0;
      `CVD_OFS_CTRL1_ALIAS: reg_home = `CVD_OFS_CTRL1;
      default:              reg_home = a;
    endcase
  endfunction

  // result layout follows the format bit: {high, low}
  function automatic logic [15:0] justify(input logic fmt, input logic [9:0] r);
    justify = fmt ? {6'h00, r} : {r, 6'h00};
  endfunction

  // first timed stage; zero counts skip their stage
  function automatic cvd_state_type first_stage(input logic [7:0] p, input logic [7:0] q);
    if (p[6:0] != 7'h00) begin
      first_stage = CVD_PRE;
    end else if (q[6:0] != 7'h00) begin
      first_stage = CVD_ACQ;
    end else begin
      first_stage = CVD_CONV;
    end
  endfunction

  // status stage code: gap reads as not converting
  function automatic logic [1:0] stage_code(input cvd_state_type st);
    unique case (st)
      CVD_PRE:  stage_code = 2'h1;
      CVD_ACQ:  stage_code = 2'h2;
      CVD_CONV: stage_code = 2'h3;
      default:  stage_code = 2'h0;
    endcase
  endfunction

  assign home      = reg_home(reg_addr_i);
  assign trig_edge = trig_src_i & ~s.trig_prev;
  // codes 6 and 7 are reserved and never trigger
  assign trig_hit  = (s.trig[6:4] != 3'h0) && (s.trig[6:4] <= 3'h5)
                     && trig_edge[s.trig[6:4] - 3'h1];

  // register writes, then sequencer; hardware set of go wins over a register-write clear
  always_comb begin
    n           = s;
    n.start     = 1'b0;
    n.done      = 1'b0;
    n.trig_prev = trig_src_i;
    if (reg_wr_i) begin
      unique case (home)
        `CVD_OFS_CTRL0: n.ctrl0 = {1'b0, reg_wdata_i[6:0]};
        `CVD_OFS_CTRL1: n.ctrl1 = {reg_wdata_i[7:4], 2'b00, reg_wdata_i[1:0]};
        `CVD_OFS_TRIG:  n.trig  = {1'b0, reg_wdata_i[6:4], 4'h0};
        `CVD_OFS_POL:   n.pol   = {reg_wdata_i[7:3], 1'b0, reg_wdata_i[1:0]};
        `CVD_OFS_PRE:   n.pre   = {1'b0, reg_wdata_i[6:0]};
        `CVD_OFS_ACQ:   n.acq   = {1'b0, reg_wdata_i[6:0]};
        `CVD_OFS_GRD:   n.grd   = {reg_wdata_i[7:5], 5'h00};
        `CVD_OFS_CAP:   n.cap   = {5'h00, reg_wdata_i[2:0]};
        `CVD_OFS_RES0L: n.res0[7:0]  = reg_wdata_i;
        `CVD_OFS_RES0H: n.res0[15:8] = reg_wdata_i;
        `CVD_OFS_RES1L: n.res1[7:0]  = reg_wdata_i;
        `CVD_OFS_RES1H: n.res1[15:8] = reg_wdata_i;
        default: ;
      endcase
    end
    if (trig_hit && n.ctrl0[`CVD_BIT_ON]) begin
      n.ctrl0[`CVD_BIT_GO] = 1'b1;
    end
    on  = n.ctrl0[`CVD_BIT_ON];
    go  = n.ctrl0[`CVD_BIT_GO];
    dbl = s.pol[`CVD_BIT_DSEN];
    // turning off or clearing go ends the sequence, with a partial result only if it stops in conversion
    if (s.st != CVD_IDLE && (!on || !go)) begin
      if (s.st == CVD_CONV) begin
        if (s.second) begin
          n.res1 = justify(s.ctrl1[`CVD_BIT_FMT], conv_result_i);
        end else begin
          n.res0 = justify(s.ctrl1[`CVD_BIT_FMT], conv_result_i);
        end
      end
      n.ctrl0[`CVD_BIT_GO] = 1'b0;
      n.st = CVD_IDLE;
    end else begin
      unique case (s.st)
        CVD_IDLE: begin
          if (on && go) begin
            n.second = 1'b0;
            if (dbl) begin
              n.res1 = 16'h0000;
            end
            n.st = first_stage(n.pre, n.acq);
          end
        end
        CVD_PRE: begin
          if (tmr_done) begin
            // acquisition follows at once, or conversion if it is off
            n.st = (s.acq[6:0] != 7'h00) ? CVD_ACQ : CVD_CONV;
          end
        end
        CVD_ACQ: begin
          if (tmr_done) begin
            n.st = CVD_CONV;
          end
        end
        CVD_CONV: begin
          if (conv_done_i) begin
            if (dbl && !s.second) begin
              n.res0   = justify(s.ctrl1[`CVD_BIT_FMT], conv_result_i);
              n.second = 1'b1;
              n.st     = CVD_GAP;
            end else begin
              if (s.second) begin
                n.res1 = justify(s.ctrl1[`CVD_BIT_FMT], conv_result_i);
              end else begin
                n.res0 = justify(s.ctrl1[`CVD_BIT_FMT], conv_result_i);
              end
              n.ctrl0[`CVD_BIT_GO] = 1'b0;
              n.done = 1'b1;
              n.st   = CVD_IDLE;
            end
          end
        end
        CVD_GAP: begin
          if (tmr_done) begin
            n.st = first_stage(s.pre, s.acq);
          end
        end
        default: n.st = CVD_IDLE;
      endcase
    end
    n.start = (n.st == CVD_CONV) && (s.st != CVD_CONV);
    // read data registered one cycle after the address
    unique case (home)
      `CVD_OFS_CTRL0: rv = s.ctrl0;
      `CVD_OFS_CTRL1: rv = s.ctrl1;
      `CVD_OFS_TRIG:  rv = s.trig;
      `CVD_OFS_POL:   rv = s.pol; // stored polarity, never the inverted one
      `CVD_OFS_STAT:  rv = {5'h00, s.ctrl0[`CVD_BIT_GO], stage_code(s.st)};
      `CVD_OFS_PRE:   rv = s.pre;
      `CVD_OFS_ACQ:   rv = s.acq;
      `CVD_OFS_GRD:   rv = s.grd;
      `CVD_OFS_CAP:   rv = s.cap;
      `CVD_OFS_RES0L: rv = s.res0[7:0];
      `CVD_OFS_RES0H: rv = s.res0[15:8];
      `CVD_OFS_RES1L: rv = s.res1[7:0];
      `CVD_OFS_RES1H: rv = s.res1[15:8];
      default:        rv = 8'h00;
    endcase
    n.rdata = rv;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // timer reloads on every stage change
  assign tmr_load  = (n.st != s.st);
  assign tmr_count = (n.st == CVD_PRE) ? n.pre[6:0] :
                     (n.st == CVD_ACQ) ? n.acq[6:0] : `CVD_GAP_CYCLES;

  cvd_stage_timer #(
    .W (7)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );

  // second-pass inversion uses the stage about to start
  assign inv = n.second & s.pol[`CVD_BIT_DSEN] & s.pol[`CVD_BIT_IPEN];
  assign sq.seq_st    = s.st;
  assign sq.inv2      = inv;
  assign sq.pre_start = (n.st == CVD_PRE) && (s.st != CVD_PRE);
  assign sq.acq_start = (n.st == CVD_ACQ) && (s.st != CVD_ACQ);
  assign sq.conv_on   = s.ctrl0[`CVD_BIT_ON];
  assign sq.grd_a_en  = s.grd[`CVD_BIT_GRD_A];
  assign sq.grd_b_en  = s.grd[`CVD_BIT_GRD_B];
  assign sq.grd_pol   = s.grd[`CVD_BIT_GRD_POL];
  assign sq.ovr_en    = s.pol[`CVD_BIT_OOEN];
  assign sq.int_pol   = s.pol[`CVD_BIT_IPPOL];

  cvd_guard_drive u_guard (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .sq           (sq),
    .guard_a_o    (guard_a_o),
    .guard_a_oe_o (guard_a_oe_o),
    .guard_b_o    (guard_b_o),
    .guard_b_oe_o (guard_b_oe_o),
    .mon_pin_o    (mon_pin_o),
    .mon_pin_oe_o (mon_pin_oe_o)
  );

  // core handshake and analog switch controls
  assign reg_rdata_o      = s.rdata;
  assign conv_start_o     = s.start;
  assign irq_set_o        = s.done; // flag itself is cleared by software
  assign chan_sel_o       = s.ctrl0[6:2];
  assign pad_override_o   = (s.st == CVD_PRE);
  assign hold_pre_level_o = s.pol[`CVD_BIT_IPPOL] ^ (s.second & s.pol[`CVD_BIT_IPEN]
                            & s.pol[`CVD_BIT_DSEN]);
  assign pad_pre_level_o  = s.pol[`CVD_BIT_EPPOL] ^ (s.second & s.pol[`CVD_BIT_IPEN]
                            & s.pol[`CVD_BIT_DSEN]);
  // extra capacitance only while charging, so conversion sees bare hold cap
  assign extra_cap_o      = (s.st == CVD_PRE || s.st == CVD_ACQ) ? s.cap[2:0]
                            : 3'h0;
  assign passgate_o       = s.pol[`CVD_BIT_OEN];
  assign low_z_o          = s.pol[`CVD_BIT_OLEN];

  a_cap_off_conv: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s.st == CVD_CONV) |-> (extra_cap_o == 3'h0))
    else $error("extra capacitance attached during conversion");
  a_gap_two_cycles: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s.st == CVD_CONV && conv_done_i && s.pol[`CVD_BIT_DSEN] && !s.second && go && on)
    |=> (s.st == CVD_GAP) ##1 (s.st == CVD_GAP) ##1 (s.st != CVD_GAP))
    else $error("second conversion gap not two cycles");
  a_pre_skipped: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s.st == CVD_IDLE && n.st != CVD_IDLE && n.pre[6:0] == 7'h00) |=> (s.st != CVD_PRE))
    else $error("pre-charge ran with zero count");
  a_end_signals: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_set_o |-> (!s.ctrl0[`CVD_BIT_GO] && s.st == CVD_IDLE))
    else $error("interrupt request without go cleared");
  a_alias_write: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (reg_wr_i && reg_addr_i == `CVD_OFS_CTRL0_ALIAS && !trig_hit
     && s.st == CVD_IDLE) |=> (s.ctrl0[6:2] == $past(reg_wdata_i[6:2])))
    else $error("low-bank control write not seen in sensing bank");
  a_pol_stored: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !$past(reg_wr_i) |-> $stable(s.grd))
    else $error("stored guard polarity changed by hardware");
  a_result_second: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (s.st == CVD_CONV && conv_done_i && s.second && go && on)
    |=> (s.res1 == justify($past(s.ctrl1[`CVD_BIT_FMT]), $past(conv_result_i))))
    else $error("second result not in second pair");
endmodule

// ### verification/cvd_core_model.sv
// converter core stand-in: answers each start pulse with a done pulse
// assumes start_i is a one-cycle registered pulse on clk_i
`timescale 1ns/10ps
module cvd_core_model (
  // clock
  input  wire logic       clk_i,
  // handshake and answer
  input  wire logic       start_i,
  input  wire logic [3:0] lat_i,
  input  wire logic [9:0] res_i,
  output logic            done_o,
  output logic      [9:0] result_o
);
  // result bus carries junk outside the done cycle, so a late sample shows
  // outputs move by non-blocking assignment on the edge, never racing the
  // bench's own 1 ns sampling; lat_i must be 1 or more
  initial begin
    done_o <= 1'b0;
    result_o <= 10'h3ff;
    forever begin
      @(posedge clk_i);
      if (start_i === 1'b1) begin
        repeat (lat_i - 4'h1) @(posedge clk_i);
        done_o <= 1'b1;
        result_o <= res_i;
        @(posedge clk_i);
        done_o <= 1'b0;
        result_o <= ~res_i;
      end
    end
  end
endmodule

// ### verification/testbench.sv
// self-checking bench for the sensing sequencer and its pin drive
// assumes the core stand-in of cvd_core_model.sv on the converter side
`timescale 1ns/10ps
`include "cvd_defs.svh"
module testbench;
  import cvd_pkg::*;
  logic        clk_i, rst_b_i, reg_wr_i, conv_start_o, conv_done_i;
  logic        hold_pre_level_o, pad_override_o, pad_pre_level_o;
  logic        passgate_o, low_z_o, irq_set_o, guard_a_o, guard_a_oe_o;
  logic        guard_b_o, guard_b_oe_o, mon_pin_o, mon_pin_oe_o, seen;
  logic [11:0] reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o;
  logic [4:0]  trig_src_i, chan_sel_o;
  logic [9:0]  conv_result_i, core_res;
  logic [3:0]  lat;
  logic [2:0]  extra_cap_o;
  int          failures, num_checks, n;

  cvd_guard_and_bus_control uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .trig_src_i(trig_src_i),
    .conv_start_o(conv_start_o), .chan_sel_o(chan_sel_o), .conv_done_i(conv_done_i),
    .conv_result_i(conv_result_i), .hold_pre_level_o(hold_pre_level_o),
    .pad_override_o(pad_override_o), .pad_pre_level_o(pad_pre_level_o),
    .extra_cap_o(extra_cap_o), .passgate_o(passgate_o), .low_z_o(low_z_o),
    .irq_set_o(irq_set_o), .guard_a_o(guard_a_o), .guard_a_oe_o(guard_a_oe_o),
    .guard_b_o(guard_b_o), .guard_b_oe_o(guard_b_oe_o), .mon_pin_o(mon_pin_o),
    .mon_pin_oe_o(mon_pin_oe_o));

  cvd_core_model core (.clk_i(clk_i), .start_i(conv_start_o), .lat_i(lat),
    .res_i(core_res), .done_o(conv_done_i), .result_o(conv_result_i));

  // 40 MHz clock
  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h want %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // inputs move 1 ns after the edge, never on it
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  // strobe dropped after its edge, so back-to-back calls leave one idle edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    step();
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    step();
    reg_wr_i = 1'b0;
  endtask

  // read data is registered, one cycle behind the address
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    step();
    reg_addr_i = a;
    step();
    chk(reg_rdata_o, e);
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: sel = pad_override_o;
      1: sel = conv_start_o;
      2: sel = irq_set_o;
      default: sel = conv_done_i;
    endcase
  endfunction

  task automatic wait_on(input int w, input logic lvl);
    int k;
    k = 0;
    while (sel(w) !== lvl && k < 300) begin
      step();
      k++;
    end
    if (k >= 300) begin
      failures++;
      $display("ERROR %0t: wait timed out", $time);
      stop_test();
    end
  endtask

  initial begin
    rst_b_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_addr_i = 12'h000;
    reg_wdata_i = 8'h00;
    trig_src_i = 5'h00;
    core_res = 10'h2a5;
    lat = 4'h1;
    failures = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    // reset value, read-only status, unmapped place
    rdc(`CVD_OFS_GRD, 8'h00);
    wr(`CVD_OFS_STAT, 8'hff);
    rdc(`CVD_OFS_STAT, 8'h00);
    wr(12'h720, 8'h5a);
    rdc(12'h720, 8'h00);
    // low bank and sensing bank share storage, both directions
    wr(`CVD_OFS_RES0L_ALIAS, 8'h3c);
    rdc(`CVD_OFS_RES0L, 8'h3c);
    wr(`CVD_OFS_CTRL1, 8'h80);
    rdc(`CVD_OFS_CTRL1_ALIAS, 8'h80);
    // guards enabled but converter off, then on with no sequence running
    wr(`CVD_OFS_GRD, 8'he0);
    step();
    chk({guard_a_oe_o, guard_b_oe_o}, 2'b00);
    wr(`CVD_OFS_CTRL0_ALIAS, 8'h01);
    step();
    chk({guard_a_oe_o, guard_b_oe_o}, 2'b11);
    // single pass: pre 2, acq 1, override and passgate on
    wr(`CVD_OFS_POL, 8'h58);
    wr(`CVD_OFS_PRE, 8'h02);
    wr(`CVD_OFS_ACQ, 8'h01);
    wr(`CVD_OFS_CAP, 8'h05);
    wr(`CVD_OFS_CTRL0, 8'h03);
    wait_on(0, 1'b1);
    chk({guard_a_o, guard_b_o}, 2'b11);
    chk({mon_pin_oe_o, mon_pin_o, hold_pre_level_o, pad_pre_level_o}, 4'b1110);
    chk(extra_cap_o, 3'h5);
    chk({passgate_o, low_z_o}, 2'b10);
    n = 0;
    while (pad_override_o === 1'b1 && n < 300) begin
      step();
      n++;
    end
    chk(16'(n), 2);
    chk({guard_a_o, guard_b_o}, 2'b01);
    chk(mon_pin_oe_o, 1'b0);
    chk(extra_cap_o, 3'h5);
    step();
    chk({conv_start_o, extra_cap_o}, 4'h8);
    wait_on(3, 1'b1);
    step();
    chk(irq_set_o, 1'b1);
    step();
    // one pulse only: the flag outside stays set until software clears it
    chk(irq_set_o, 1'b0);
    rdc(`CVD_OFS_CTRL0, 8'h01);
    rdc(`CVD_OFS_RES0H, 8'h02);
    rdc(`CVD_OFS_RES0L_ALIAS, 8'ha5);
    rdc(`CVD_OFS_GRD, 8'he0);
    // double sample with invert, slow core answer, low-z path
    // monitor pin taken as an input by the port while the path is on
    core_res = 10'h1c3;
    lat = 4'h6;
    wr(`CVD_OFS_POL, 8'h63);
    wr(`CVD_OFS_CTRL0, 8'h03);
    wait_on(3, 1'b1);
    core_res = 10'h15a;
    n = 0;
    do begin
      step();
      n++;
    end while (pad_override_o !== 1'b1 && n < 20);
    chk(16'(n), 3);
    chk({guard_a_o, guard_b_o, hold_pre_level_o, pad_pre_level_o}, 4'b0001);
    chk({passgate_o, low_z_o, mon_pin_oe_o}, 3'b010);
    wait_on(0, 1'b0);
    chk({guard_a_o, guard_b_o}, 2'b10);
    wait_on(2, 1'b1);
    rdc(`CVD_OFS_RES0H, 8'h01);
    rdc(`CVD_OFS_RES0L, 8'hc3);
    rdc(`CVD_OFS_RES1H, 8'h01);
    rdc(`CVD_OFS_RES1L, 8'h5a);
    rdc(`CVD_OFS_POL, 8'h63);
    // trigger code 1 start with both stages skipped
    wr(`CVD_OFS_POL, 8'h00);
    wr(`CVD_OFS_PRE, 8'h00);
    wr(`CVD_OFS_ACQ, 8'h00);
    wr(`CVD_OFS_TRIG, 8'h10);
    trig_src_i = 5'h01;
    seen = 1'b0;
    n = 0;
    while (conv_start_o !== 1'b1 && n < 20) begin
      step();
      seen = seen | pad_override_o;
      n++;
    end
    chk({seen, conv_start_o}, 2'b01);
    wait_on(2, 1'b1);
    trig_src_i = 5'h00;
    // converter off hands both guard pins back to the port
    wr(`CVD_OFS_CTRL0, 8'h00);
    step();
    chk({guard_a_oe_o, guard_b_oe_o}, 2'b00);
    // channel field written through the low bank shows on the select lines
    wr(`CVD_OFS_CTRL0_ALIAS, 8'h54);
    chk(chan_sel_o, 5'h15);
    stop_test();
  end
endmodule
